// file: shared/balu_defs.svh
// Register offsets, field positions and reset values of the byte ALU.
`ifndef BALU_DEFS_SVH
`define BALU_DEFS_SVH

`define BALU_ADDR_W      8
`define BALU_CTRL_OFS    8'h00
`define BALU_DEST_OFS    8'h04
`define BALU_SRC_OFS     8'h08
`define BALU_IMM_OFS     8'h0C
`define BALU_FLAG_OFS    8'h10

`define BALU_CTRL_OP_MSB 4
`define BALU_CTRL_OP_LSB 0
`define BALU_CTRL_START  8
`define BALU_CTRL_BUSY   16

`define BALU_FLAG_C      0
`define BALU_FLAG_Z      1
`define BALU_FLAG_N      2
`define BALU_FLAG_V      3
`define BALU_FLAG_S      4
`define BALU_FLAG_H      5
`define BALU_FLAG_W      6

`define BALU_FLAG_RST    6'h00
`define BALU_DEST_RST    16'h0000
`define BALU_BYTE_RST    8'h00
`define BALU_OP_RST      5'h00

`endif

// file: shared/balu_pkg.sv
// Types shared by the byte ALU design files.
package balu_pkg;

    typedef logic [5:0] balu_flags_t;

    typedef enum logic [4:0] {
        ADD_REG_OP                  = 5'h00,
        ADD_CARRY_OP                = 5'h01,
        WORD_ADD_IMMEDIATE_OP       = 5'h02,
        SUBTRACT_REG_OP             = 5'h03,
        SUBTRACT_IMMEDIATE_OP       = 5'h04,
        SUBTRACT_WITH_CARRY_OP      = 5'h05,
        SUBTRACT_CARRY_IMMEDIATE_OP = 5'h06,
        WORD_SUBTRACT_IMMEDIATE_OP  = 5'h07,
        AND_REG_OP                  = 5'h08,
        AND_IMMEDIATE_OP            = 5'h09,
        OR_REG_OP                   = 5'h0A,
        OR_IMMEDIATE_OP             = 5'h0B,
        EXCLUSIVE_OR_OP             = 5'h0C,
        ONES_COMPLEMENT_OP          = 5'h0D,
        TWOS_COMPLEMENT_OP          = 5'h0E,
        SET_BITS_OP                 = 5'h0F,
        CLEAR_BITS_OP               = 5'h10,
        INCREMENT_OP                = 5'h11,
        DECREMENT_OP                = 5'h12,
        TEST_VALUE_OP               = 5'h13,
        CLEAR_REG_OP                = 5'h14,
        SET_REG_OP                  = 5'h15
    } balu_op_e;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h1,
        ST_EXEC    = 3'h2,
        ST_WORD_HI = 3'h4
    } balu_state_e;

endpackage

// file: hdl/balu_addsub.sv
// Eight-bit adder and subtractor with carry, half-carry and overflow.
`timescale 1ns/1ps

module balu_addsub (
    // Operands
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] b_i,
    input  wire logic       cin_i,
    input  wire logic       sub_i,
    // Result
    output logic      [7:0] res_o,
    output logic            carry_o,
    output logic            half_o,
    output logic            ovf_o
);

    // Subtraction runs as a + ~b + ~cin, so carry and half-carry come
    // out inverted and are turned back into borrows below.
    wire logic [7:0] b_x  = b_i ^ {8{sub_i}};
    wire logic       ci_x = cin_i ^ sub_i;
    wire logic [4:0] lo   = {1'h0, a_i[3:0]} + {1'h0, b_x[3:0]} + {4'h0, ci_x};
    wire logic [8:0] full = {1'h0, a_i} + {1'h0, b_x} + {8'h00, ci_x};

    assign res_o   = full[7:0];
    assign carry_o = full[8] ^ sub_i;
    assign half_o  = lo[4] ^ sub_i;
    assign ovf_o   = (a_i[7] == b_x[7]) & (full[7] != a_i[7]);

endmodule

// file: hdl/balu_top.sv
// Byte ALU datapath with APB register access.
`timescale 1ns/1ps
`include "balu_defs.svh"

module balu_top (
    // Clock and reset
    input  wire logic                    clk_sys_i,
    input  wire logic                    reset_n_i,
    // APB slave
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [7:0]              paddr_i,
    input  wire logic [31:0]             pwdata_i,
    input  wire logic [3:0]              pstrb_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    // Status
    output logic                         busy_o,
    output logic                         done_o,
    output balu_pkg::balu_flags_t        flags_o
);
    import balu_pkg::*;

    balu_state_e state_ff;
    balu_state_e nxt_state;
    balu_op_e    op_ff;
    balu_flags_t flags_ff;
    balu_flags_t nxt_flags;
    logic [15:0] dest_ff;
    logic [7:0]  src_ff;
    logic [7:0]  imm_ff;
    logic        wcarry_ff;
    logic        wzero_ff;
    logic        busy_ff;
    logic        done_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;

    // APB decode. The slave answers in the first access cycle because
    // pready is raised by the setup cycle one edge earlier.
    wire logic setup    = psel_i & ~penable_i;
    wire logic acc_done = psel_i & penable_i & pready_ff;
    wire logic hit_ctrl = paddr_i == `BALU_CTRL_OFS;
    wire logic hit_dest = paddr_i == `BALU_DEST_OFS;
    wire logic hit_src  = paddr_i == `BALU_SRC_OFS;
    wire logic hit_imm  = paddr_i == `BALU_IMM_OFS;
    wire logic hit_flag = paddr_i == `BALU_FLAG_OFS;
    wire logic addr_ok  = hit_ctrl | hit_dest | hit_src | hit_imm | hit_flag;
    wire logic st_idle  = state_ff == ST_IDLE;
    wire logic st_exec  = state_ff == ST_EXEC;
    wire logic st_hi    = state_ff == ST_WORD_HI;

    // Operand writes are dropped while an operation runs, so software
    // can never tear a result that the datapath is about to store.
    wire logic wr_ok    = acc_done & pwrite_i & st_idle;
    wire logic wr_ctrl  = wr_ok & hit_ctrl & pstrb_i[1];
    wire logic start    = wr_ctrl & pwdata_i[`BALU_CTRL_START];
    wire logic wr_dlo   = wr_ok & hit_dest & pstrb_i[0];
    wire logic wr_dhi   = wr_ok & hit_dest & pstrb_i[1];
    wire logic wr_src   = wr_ok & hit_src & pstrb_i[0];
    wire logic wr_imm   = wr_ok & hit_imm & pstrb_i[0];
    wire logic wr_flag  = wr_ok & hit_flag & pstrb_i[0];
    wire logic [4:0] wr_op =
        pwdata_i[`BALU_CTRL_OP_MSB:`BALU_CTRL_OP_LSB];

    wire logic [31:0] rd_ctrl = {15'h0000, busy_ff, 11'h000, op_ff};
    wire logic [31:0] rd_mux  =
        hit_ctrl ? rd_ctrl :
        hit_dest ? {16'h0000, dest_ff} :
        hit_src  ? {24'h000000, src_ff} :
        hit_imm  ? {24'h000000, imm_ff} :
        hit_flag ? {26'h0000000, flags_ff} : 32'h00000000;

    // Operation classes.
    wire logic is_arith = op_ff inside {ADD_REG_OP, ADD_CARRY_OP,
        SUBTRACT_REG_OP, SUBTRACT_IMMEDIATE_OP, SUBTRACT_WITH_CARRY_OP,
        SUBTRACT_CARRY_IMMEDIATE_OP, ONES_COMPLEMENT_OP, TWOS_COMPLEMENT_OP};
    wire logic is_word  = op_ff inside {WORD_ADD_IMMEDIATE_OP,
        WORD_SUBTRACT_IMMEDIATE_OP};
    wire logic is_incd  = op_ff inside {INCREMENT_OP, DECREMENT_OP};
    wire logic is_logic = op_ff inside {AND_REG_OP, AND_IMMEDIATE_OP,
        OR_REG_OP, OR_IMMEDIATE_OP, EXCLUSIVE_OR_OP, SET_BITS_OP,
        CLEAR_BITS_OP, TEST_VALUE_OP, CLEAR_REG_OP};
    wire logic is_set   = op_ff == SET_REG_OP;
    wire logic is_com   = op_ff == ONES_COMPLEMENT_OP;
    wire logic op_legal = is_arith | is_word | is_incd | is_logic | is_set;

    wire logic [7:0] d_lo = dest_ff[7:0];
    wire logic [7:0] d_hi = dest_ff[15:8];
    wire logic       c_in = flags_ff[`BALU_FLAG_C];

    logic [7:0] add_a;
    logic [7:0] add_b;
    logic       add_cin;
    logic       add_sub;
    logic [7:0] add_res;
    logic       add_c;
    logic       add_h;
    logic       add_v;
    logic [7:0] logic_res;

    // Adder operand selection; the word forms use the low byte first
    // and then the high byte with the stored carry or borrow.
    always_comb begin
        add_a   = d_lo;
        add_b   = src_ff;
        add_cin = 1'h0;
        add_sub = 1'h0;
        unique case (op_ff)
            ADD_REG_OP: add_cin = 1'h0;
            ADD_CARRY_OP: add_cin = c_in;
            SUBTRACT_REG_OP: add_sub = 1'h1;
            SUBTRACT_IMMEDIATE_OP: begin
                add_sub = 1'h1;
                add_b   = imm_ff;
            end
            SUBTRACT_WITH_CARRY_OP: begin
                add_sub = 1'h1;
                add_cin = c_in;
            end
            SUBTRACT_CARRY_IMMEDIATE_OP: begin
                add_sub = 1'h1;
                add_b   = imm_ff;
                add_cin = c_in;
            end
            WORD_ADD_IMMEDIATE_OP, WORD_SUBTRACT_IMMEDIATE_OP: begin
                add_sub = op_ff == WORD_SUBTRACT_IMMEDIATE_OP;
                add_a   = st_hi ? d_hi : d_lo;
                add_b   = st_hi ? 8'h00 : imm_ff;
                add_cin = st_hi & wcarry_ff;
            end
            ONES_COMPLEMENT_OP: begin
                add_a   = 8'hFF;
                add_b   = d_lo;
                add_sub = 1'h1;
            end
            TWOS_COMPLEMENT_OP: begin
                add_a   = 8'h00;
                add_b   = d_lo;
                add_sub = 1'h1;
            end
            INCREMENT_OP: add_b = 8'h01;
            DECREMENT_OP: begin
                add_b   = 8'h01;
                add_sub = 1'h1;
            end
            default: add_b = src_ff;
        endcase
    end

    // Logic unit.
    always_comb begin
        unique case (op_ff)
            AND_REG_OP:       logic_res = d_lo & src_ff;
            AND_IMMEDIATE_OP: logic_res = d_lo & imm_ff;
            OR_REG_OP:        logic_res = d_lo | src_ff;
            OR_IMMEDIATE_OP:  logic_res = d_lo | imm_ff;
            EXCLUSIVE_OR_OP:  logic_res = d_lo ^ src_ff;
            SET_BITS_OP:      logic_res = d_lo | imm_ff;
            CLEAR_BITS_OP:    logic_res = d_lo & (8'hFF - imm_ff);
            TEST_VALUE_OP:    logic_res = d_lo & d_lo;
            CLEAR_REG_OP:     logic_res = d_lo ^ d_lo;
            SET_REG_OP:       logic_res = 8'hFF;
            default:          logic_res = d_lo;
        endcase
    end

    balu_addsub u_addsub (
        .a_i     (add_a),
        .b_i     (add_b),
        .cin_i   (add_cin),
        .sub_i   (add_sub),
        .res_o   (add_res),
        .carry_o (add_c),
        .half_o  (add_h),
        .ovf_o   (add_v)
    );

    wire logic [7:0] res  = (is_logic | is_set) ? logic_res : add_res;
    wire logic       z8   = res == 8'h00;
    wire logic       w_lo = st_exec & is_word;
    wire logic       step = (st_exec & op_legal) | st_hi;

    // Flag update. Each class touches only its own flags; the word low
    // byte touches none, so a half-finished word leaves flags stable.
    always_comb begin
        nxt_flags = flags_ff;
        if (st_hi) begin
            nxt_flags[`BALU_FLAG_Z] = z8 & wzero_ff;
            nxt_flags[`BALU_FLAG_C] = add_c;
            nxt_flags[`BALU_FLAG_N] = res[7];
            nxt_flags[`BALU_FLAG_V] = add_v;
            nxt_flags[`BALU_FLAG_S] = res[7] ^ add_v;
        end else if (st_exec & ~is_word & ~is_set & op_legal) begin
            nxt_flags[`BALU_FLAG_Z] = z8;
            nxt_flags[`BALU_FLAG_N] = res[7];
            nxt_flags[`BALU_FLAG_V] = is_logic ? 1'h0 : add_v;
            if (is_arith) begin
                nxt_flags[`BALU_FLAG_C] = add_c;
            end
            if (is_arith & ~is_com) begin
                nxt_flags[`BALU_FLAG_H] = add_h;
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:    if (start) nxt_state = ST_EXEC;
            ST_EXEC:    nxt_state = is_word ? ST_WORD_HI : ST_IDLE;
            ST_WORD_HI: nxt_state = ST_IDLE;
            default:    nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_IDLE;
            busy_ff  <= 1'h0;
            done_ff  <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= nxt_state != ST_IDLE;
            done_ff  <= (st_exec & ~is_word) | st_hi;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            op_ff <= balu_op_e'(`BALU_OP_RST);
        end else if (wr_ctrl & pstrb_i[0]) begin
            op_ff <= balu_op_e'(wr_op);
        end
    end

    // Result write-back to the destination byte or pair.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dest_ff <= `BALU_DEST_RST;
        end else if (st_hi) begin
            dest_ff[15:8] <= res;
        end else if (step & ~(is_logic & op_ff == TEST_VALUE_OP)) begin
            dest_ff[7:0] <= res;
        end else begin
            if (wr_dlo) dest_ff[7:0] <= pwdata_i[7:0];
            if (wr_dhi) dest_ff[15:8] <= pwdata_i[15:8];
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wcarry_ff <= 1'h0;
            wzero_ff  <= 1'h0;
        end else if (w_lo) begin
            wcarry_ff <= add_c;
            wzero_ff  <= z8;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_ff <= `BALU_FLAG_RST;
        end else if (step) begin
            flags_ff <= nxt_flags;
        end else if (wr_flag) begin
            flags_ff <= pwdata_i[`BALU_FLAG_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            src_ff <= `BALU_BYTE_RST;
            imm_ff <= `BALU_BYTE_RST;
        end else begin
            if (wr_src) src_ff <= pwdata_i[7:0];
            if (wr_imm) imm_ff <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_ff  <= 1'h0;
            pslverr_ff <= 1'h0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~addr_ok;
            if (setup) prdata_ff <= pwrite_i ? 32'h00000000 : rd_mux;
        end
    end

    assign prdata_o  = prdata_ff;
    assign pready_o  = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign busy_o    = busy_ff;
    assign done_o    = done_ff;
    assign flags_o   = flags_ff;

endmodule

// file: tb/balu_checker.sv
// Port-level assertions for the byte ALU, bound into its top module.
`timescale 1ns/1ps
`include "balu_defs.svh"

module balu_checker (
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  reset_n_i,
    // APB slave
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [7:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    input  wire logic [3:0]            pstrb_i,
    input  wire logic                  pready_o,
    input  wire logic                  pslverr_o,
    // Status
    input  wire logic                  busy_o,
    input  wire logic                  done_o,
    input  wire balu_pkg::balu_flags_t flags_o
);
    import balu_pkg::*;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    wire acc_wr = psel_i & penable_i & pwrite_i & pready_o;
    // Opcode and start must share the write, else the opcode is stale.
    wire go     = acc_wr & (paddr_i == `BALU_CTRL_OFS) & pstrb_i[0]
                  & pstrb_i[1] & pwdata_i[`BALU_CTRL_START] & !busy_o;
    wire word   = pwdata_i[4:0] inside {5'h02, 5'h07};
    wire mapped = paddr_i inside {`BALU_CTRL_OFS, `BALU_DEST_OFS,
                  `BALU_SRC_OFS, `BALU_IMM_OFS, `BALU_FLAG_OFS};

    setup_ready_a: assert property (psel_i && !penable_i |=> pready_o)
        else $error("No ready in the cycle after an APB setup.");
    ready_gate_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("Ready raised outside an access cycle.");
    err_map_a: assert property (pready_o |-> pslverr_o == !mapped)
        else $error("Slave error does not match the address map.");
    byte_time_a: assert property (go && !word |=> busy_o ##1 !busy_o)
        else $error("Byte operation did not take one cycle.");
    word_time_a: assert property (go && word |=> busy_o[*2] ##1 !busy_o)
        else $error("Word operation did not take two cycles.");
    done_end_a: assert property ($fell(busy_o) |-> done_o)
        else $error("Done missing when the operation ended.");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("Done lasted more than one cycle.");
    flag_cause_a: assert property ($changed(flags_o) |-> done_o
        || $past(acc_wr && paddr_i == `BALU_FLAG_OFS))
        else $error("Flags changed with no operation or write.");
endmodule

bind balu_top balu_checker i_chk (.clk_sys_i, .reset_n_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pready_o,
    .pslverr_o, .busy_o, .done_o, .flags_o);

// file: tb/test_byte_alu_arith_logic.sv
// Self-checking bench for the byte ALU datapath.
`timescale 1ns/1ps
`include "balu_defs.svh"

module test_byte_alu_arith_logic;
    import balu_pkg::*;

    logic        clk, rst_n, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr, busy, done;
    balu_flags_t flags;
    int          bad_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [3:0]  strb_w = 4'hF;

    balu_top i_dut (.clk_sys_i(clk), .reset_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .busy_o(busy),
        .done_o(done), .flags_o(flags));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic results;
        if (bad_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // A hung handshake never returns, so the cycle ceiling ends the run.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // With hold set, psel stays up so the next setup follows at once.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic hold,
                       output logic [31:0] rd, output logic er);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= w ? strb_w : 4'h0;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
        if (!hold) begin
            psel <= 1'b0;
            @(posedge clk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, 1'b0, r, e);
    endtask

    function automatic logic [21:0] model(input logic [4:0] op,
        input logic [15:0] d, input logic [7:0] s, k, input logic [5:0] f);
        logic [8:0]  r;
        logic [16:0] w;
        logic [7:0]  a, b, y;
        logic [5:0]  o;
        logic [15:0] nd;
        logic        sb, ci, h, v, ar, zn;
        sb = op inside {5'h03, 5'h04, 5'h05, 5'h06, 5'h0E, 5'h12};
        ci = f[0] & (op inside {5'h01, 5'h05, 5'h06});
        ar = op inside {5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0E};
        zn = op inside {[5'h08 : 5'h14]};
        a = (op == 5'h0E) ? 8'h00 : d[7:0];
        b = (op == 5'h0E) ? d[7:0] : (op inside {5'h04, 5'h06}) ? k : s;
        if (op inside {5'h11, 5'h12})
            b = 8'h01;
        r = sb ? {1'b0, a} - {1'b0, b} - ci : {1'b0, a} + {1'b0, b} + ci;
        h = sb ? ({1'b0, a[3:0]} < {1'b0, b[3:0]} + ci)
               : ({1'b0, a[3:0]} + {1'b0, b[3:0]} + ci > 5'h0F);
        v = ((a[7] ^ b[7]) == sb) && (r[7] != a[7]);
        case (op)
            5'h08: y = a & s;
            5'h09: y = a & k;
            5'h0A: y = a | s;
            5'h0B, 5'h0F: y = a | k;
            5'h0C: y = a ^ s;
            5'h0D: y = ~a;
            5'h10: y = a & ~k;
            5'h13: y = a;
            5'h14: y = 8'h00;
            default: y = r[7:0];
        endcase
        o = f;
        nd = d;
        if (ar || zn) begin
            nd[7:0] = y;
            o[1] = (y == 8'h00);
            o[2] = y[7];
            o[3] = (ar || op inside {5'h11, 5'h12}) && v;
        end
        if (ar) begin
            o[0] = r[8];
            o[5] = h;
        end
        if (op == 5'h0D)
            o[0] = 1'b0;
        if (op == 5'h15)
            nd[7:0] = 8'hFF;
        if (op inside {5'h02, 5'h07}) begin
            w = (op == 5'h02) ? {1'b0, d} + k : {1'b0, d} - k;
            nd = w[15:0];
            o[0] = w[16];
            o[1] = (w[15:0] == 16'h0000);
            o[2] = w[15];
            o[3] = (op == 5'h02) ? (!d[15] && w[15]) : (d[15] && !w[15]);
            o[4] = o[2] ^ o[3];
        end
        return {nd, o};
    endfunction

    task automatic one(input logic [4:0] op, input logic [15:0] d,
                       input logic [7:0] s, k, input logic [5:0] f);
        logic [31:0] r;
        logic        er;
        int          n;
        wr(`BALU_DEST_OFS, {16'h0000, d});
        wr(`BALU_SRC_OFS, {24'h000000, s});
        wr(`BALU_IMM_OFS, {24'h000000, k});
        wr(`BALU_FLAG_OFS, {26'h0000000, f});
        apb(1'b1, `BALU_CTRL_OFS, {23'h000000, 1'b1, 3'h0, op}, 1'b0, r, er);
        n = 1;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        apb(1'b0, `BALU_DEST_OFS, 32'h00000000, 1'b0, r, er);
        chk($sformatf("op %h", op), {6'h00, n[3:0], r[15:0], flags},
            {6'h00, (op inside {5'h02, 5'h07}) ? 4'h3 : 4'h2,
             model(op, d, s, k, f)});
    endtask

    task automatic t_arith;
        one(5'h00, 16'hA57F, 8'h01, 8'h00, 6'h10);
        one(5'h01, 16'h00FF, 8'h00, 8'h00, 6'h01);
        one(5'h03, 16'h0000, 8'h01, 8'h00, 6'h00);
        one(5'h04, 16'h3C80, 8'h00, 8'h01, 6'h00);
        one(5'h05, 16'h0010, 8'h0F, 8'h00, 6'h01);
        one(5'h06, 16'h0000, 8'h00, 8'h00, 6'h01);
        one(5'h06, 16'h0050, 8'hFF, 8'h20, 6'h00);
    endtask

    task automatic t_word;
        one(5'h02, 16'h7FFF, 8'h00, 8'h01, 6'h00);
        one(5'h02, 16'hFFC1, 8'h00, 8'h3F, 6'h00);
        one(5'h07, 16'h0000, 8'h00, 8'h01, 6'h00);
        one(5'h07, 16'h8000, 8'h00, 8'h01, 6'h20);
    endtask

    task automatic t_logic;
        one(5'h08, 16'h77F0, 8'h3C, 8'h00, 6'h39);
        one(5'h09, 16'h00F0, 8'hFF, 8'h0F, 6'h39);
        one(5'h0A, 16'h0001, 8'h80, 8'h00, 6'h39);
        one(5'h0B, 16'h0001, 8'h00, 8'h80, 6'h39);
        one(5'h0C, 16'h00A5, 8'hA5, 8'h00, 6'h39);
        one(5'h0F, 16'h0010, 8'h00, 8'h81, 6'h39);
        one(5'h10, 16'h00FF, 8'h00, 8'h7F, 6'h39);
        one(5'h13, 16'h0080, 8'h00, 8'h00, 6'h39);
        one(5'h13, 16'h0000, 8'h00, 8'h00, 6'h39);
    endtask

    task automatic t_unary;
        one(5'h0D, 16'h000F, 8'h00, 8'h00, 6'h29);
        one(5'h0E, 16'h0080, 8'h00, 8'h00, 6'h00);
        one(5'h0E, 16'h0000, 8'h00, 8'h00, 6'h3F);
        one(5'h11, 16'h007F, 8'h00, 8'h00, 6'h21);
        one(5'h12, 16'h0080, 8'h00, 8'h00, 6'h21);
        one(5'h12, 16'h0001, 8'h00, 8'h00, 6'h21);
        one(5'h14, 16'h0055, 8'h00, 8'h00, 6'h3D);
        one(5'h15, 16'h0012, 8'h00, 8'h00, 6'h2A);
    endtask

    // A DEST write landing mid word-op must not disturb the result; the
    // CTRL readback, a single-lane write and an unused opcode follow.
    task automatic t_bus;
        logic [31:0] r;
        logic        er;
        apb(1'b0, 8'h14, 32'h00000000, 1'b0, r, er);
        chk("unmapped error", {31'h00000000, er}, 32'h00000001);
        chk("unmapped data", r, 32'h00000000);
        wr(`BALU_DEST_OFS, 32'h00001234);
        wr(`BALU_IMM_OFS, 32'h00000010);
        apb(1'b1, `BALU_CTRL_OFS, 32'h00000102, 1'b1, r, er);
        apb(1'b1, `BALU_DEST_OFS, 32'h00005555, 1'b0, r, er);
        apb(1'b0, `BALU_DEST_OFS, 32'h00000000, 1'b0, r, er);
        chk("word add dest", r, 32'h00001244);
        apb(1'b0, `BALU_CTRL_OFS, 32'h00000000, 1'b0, r, er);
        chk("ctrl idle", r, 32'h00000002);
        apb(1'b1, `BALU_CTRL_OFS, 32'h00000107, 1'b1, r, er);
        apb(1'b0, `BALU_CTRL_OFS, 32'h00000000, 1'b0, r, er);
        chk("ctrl busy", r, 32'h00010007);
        strb_w = 4'h1;
        wr(`BALU_DEST_OFS, 32'h0000BEEF);
        strb_w = 4'hF;
        apb(1'b0, `BALU_DEST_OFS, 32'h00000000, 1'b0, r, er);
        chk("lane write", r, 32'h000012EF);
        one(5'h16, 16'h00AB, 8'h11, 8'h22, 6'h15);
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_arith();
        t_word();
        t_logic();
        t_unary();
        t_bus();
        results();
    end
endmodule
